/* File: bench/lane_link_status_registers_tb.sv */
// Self-checking testbench for the lane link status register bank.
// Assumes word-indexed reads answered one cycle later and shortened second and rate counts.
module lane_link_status_registers_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lane_status_pkg::*;

	localparam int unsigned LANES = 12;
	localparam int unsigned LIMIT = 3000;

	typedef struct packed {logic [15:0] a; logic [31:0] e;} row_s;

	// Distinct flag patterns, one per flag group, in package group order.
	localparam logic [11:0] PAT [9] = '{12'hA5C, 12'h3F0, 12'h00F, 12'hC33, 12'h5A5,
		12'h812, 12'h7E1, 12'h0C6, 12'hFFF};

	// Ordinary reads: address beside the word it must return.
	localparam row_s ROWS [17] = '{
		'{OFS_LANE_TOTAL, 32'(LANES)},
		'{16'h0000, 32'h0000_0000},
		'{16'h0002, 32'h0000_0000},
		'{16'h000F, 32'h0000_0000},
		'{16'h0012, 32'h0000_0000},
		'{16'hFFFF, 32'h0000_0000},
		'{OFS_SEND_DRAINED, {20'h0_0000, PAT[0]}},
		'{OFS_SEND_FULL, {20'h0_0000, PAT[1]}},
		'{OFS_SEND_LOW, {20'h0_0000, PAT[2]}},
		'{OFS_SEND_HIGH, {20'h0_0000, PAT[3]}},
		'{OFS_RECV_DRAINED, {20'h0_0000, PAT[4]}},
		'{OFS_RECV_FULL, {20'h0_0000, PAT[5]}},
		'{OFS_RECV_LOW, {20'h0_0000, PAT[6]}},
		'{OFS_RECV_HIGH, {20'h0_0000, PAT[7]}},
		'{OFS_CDR_LOCK, {20'h0_0000, PAT[8]}},
		'{OFS_CORE_CLOCK_RATE, 32'h0000_0000},
		'{OFS_PLL_LOCK, 32'h0000_0002}
	};

	logic              clk_i                = 1'b0;
	logic              reset_i              = 1'b1;
	logic              ce_i                 = 1'b1;
	logic [15:0]       mgmt_address_i       = 16'h0000;
	logic              mgmt_read_i          = 1'b0;
	logic [31:0]       mgmt_readdata_o;
	logic              mgmt_readdatavalid_o;
	logic [31:0]       shared_readdata;
	logic              shared_valid;
	logic [LANES-1:0]  send_drained_i       = PAT[0];
	logic [LANES-1:0]  send_full_i          = PAT[1];
	logic [LANES-1:0]  send_low_i           = PAT[2];
	logic [LANES-1:0]  send_high_i          = PAT[3];
	logic [LANES-1:0]  recv_drained_i       = PAT[4];
	logic [LANES-1:0]  recv_full_i          = PAT[5];
	logic [LANES-1:0]  recv_low_i           = PAT[6];
	logic [LANES-1:0]  recv_high_i          = PAT[7];
	logic [LANES-1:0]  cdr_lock_i           = PAT[8];
	logic [1:0]        tx_pll_lock_i        = 2'b00;
	logic              core_pll_lock_i      = 1'b0;
	logic              core_clock_i         = 1'b0;
	logic              recovered_clock_i    = 1'b0;
	logic              serial_clock_i       = 1'b0;
	logic [31:0]       d;
	logic [31:0]       d2;
	logic [31:0]       s0;
	int                ph                   = 0;
	int                cycles               = 0;
	int                n_mismatch           = 0;
	int                n_compared           = 0;

	// Per-block variant without the core rate register; block 1 is unused.
	lane_link_status_registers #(.NUM_LANES(LANES), .NUM_XCVR_BLOCKS(2),
		.USED_BLOCKS(32'h0000_0001), .SHARED_PLL(1'b0), .HAS_CORE_RATE(1'b0),
		.CYCLES_PER_SECOND(10), .RATE_WINDOW_CYCLES(100)) dut (.*);

	// Shared PLL variant with the core rate register, fed the same inputs.
	lane_link_status_registers #(.NUM_LANES(LANES), .NUM_XCVR_BLOCKS(2),
		.USED_BLOCKS(32'h0000_0001), .SHARED_PLL(1'b1), .HAS_CORE_RATE(1'b1),
		.CYCLES_PER_SECOND(10), .RATE_WINDOW_CYCLES(100)) dut_shared (
		.mgmt_readdata_o(shared_readdata), .mgmt_readdatavalid_o(shared_valid), .*);

	// Management clock of 50 ns.
	always #25 clk_i = ~clk_i;

	// Monitored clocks with periods of 4, 10 and 20 cycles, so a 100-cycle window is exact.
	always @(negedge clk_i)
	begin
		ph <= ph + 1;
		serial_clock_i <= ph[1];
		recovered_clock_i <= (ph % 10) < 5;
		core_clock_i <= (ph % 20) < 10;
	end

	// Cuts a hang short and goes to the closing report.
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			n_mismatch++;
			results();
		end
	end

	// Compares one 32-bit result and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Issues one read at a falling edge and collects both answers one cycle later.
	task automatic rd(input logic [15:0] a);
		mgmt_address_i = a;
		mgmt_read_i = 1'b1;
		@(negedge clk_i);
		chk({31'h0000_0000, mgmt_readdatavalid_o}, 32'h0000_0001);
		chk({31'h0000_0000, shared_valid}, 32'h0000_0001);
		d = mgmt_readdata_o;
		d2 = shared_readdata;
	endtask

	// Releases the read strobe and lets cycles pass.
	task automatic idle(input int n);
		mgmt_read_i = 1'b0;
		repeat (n) @(negedge clk_i);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence.
	initial
	begin
		repeat (8) @(negedge clk_i);
		reset_i = 1'b0;
		rd(OFS_SECONDS_SINCE_START);
		chk(d, 32'h0000_0000);
		rd(OFS_SERIAL_RATE);
		chk(d, 32'h0000_0000);
		idle(4);
		$display("test after reset done");
		foreach (ROWS[i])
		begin
			rd(ROWS[i].a);
			chk(d, ROWS[i].e);
		end
		idle(2);
		$display("test table done");
		// Every per-lane flag input flips, so each group is seen to follow its own pins.
		send_drained_i = ~PAT[0];
		send_full_i = ~PAT[1];
		send_low_i = ~PAT[2];
		send_high_i = ~PAT[3];
		recv_drained_i = ~PAT[4];
		recv_full_i = ~PAT[5];
		recv_low_i = ~PAT[6];
		recv_high_i = ~PAT[7];
		cdr_lock_i = ~PAT[8];
		idle(6);
		for (int i = 0; i < 9; i++)
		begin
			rd(ROWS[i + 6].a);
			chk(d, {20'h0_0000, ~PAT[i]});
			chk(d2, {20'h0_0000, ~PAT[i]});
		end
		idle(2);
		$display("test inverted flags done");
		send_full_i = 12'h001;
		idle(6);
		rd(OFS_SEND_FULL);
		chk(d, 32'h0000_0001);
		rd(OFS_SEND_FULL);
		chk(d, 32'h0000_0001);
		$display("test live flags done");
		tx_pll_lock_i = 2'b01;
		core_pll_lock_i = 1'b1;
		idle(6);
		rd(OFS_PLL_LOCK);
		chk(d, 32'h0000_0003);
		chk(d2, 32'h0001_0001);
		tx_pll_lock_i = 2'b10;
		core_pll_lock_i = 1'b0;
		idle(6);
		rd(OFS_PLL_LOCK);
		chk(d, 32'h0000_0002);
		chk(d2, 32'h0000_0000);
		$display("test pll lock done");
		idle(200);
		rd(OFS_RECOVERED_RATE);
		chk(d, 32'h0000_000A);
		rd(OFS_SERIAL_RATE);
		chk(d, 32'h0000_0019);
		rd(OFS_CORE_CLOCK_RATE);
		chk(d, 32'h0000_0000);
		chk(d2, 32'h0000_0005);
		$display("test rates done");
		rd(OFS_SECONDS_SINCE_START);
		s0 = d;
		idle(29);
		rd(OFS_SECONDS_SINCE_START);
		chk(d, s0 + 32'h0000_0003);
		$display("test seconds done");
		// Ten enabled edges pass between the two reads, twenty frozen ones in between.
		rd(OFS_SECONDS_SINCE_START);
		s0 = d;
		idle(1);
		ce_i = 1'b0;
		mgmt_read_i = 1'b1;
		repeat (20) @(negedge clk_i);
		chk({31'h0000_0000, mgmt_readdatavalid_o}, 32'h0000_0000);
		ce_i = 1'b1;
		idle(8);
		rd(OFS_SECONDS_SINCE_START);
		chk(d, s0 + 32'h0000_0001);
		idle(2);
		reset_i = 1'b1;
		mgmt_read_i = 1'b1;
		@(negedge clk_i);
		chk({31'h0000_0000, mgmt_readdatavalid_o}, 32'h0000_0000);
		idle(1);
		reset_i = 1'b0;
		rd(OFS_SECONDS_SINCE_START);
		chk(d, 32'h0000_0000);
		rd(OFS_RECOVERED_RATE);
		chk(d, 32'h0000_0000);
		idle(1);
		$display("test freeze and reset done");
		results();
	end
endmodule

/* File: hdl/clock_rate_meter.sv */
// Counts rising edges of one sampled clock over a fixed window of management cycles.
// Assumes the sampled clock is at most a quarter of the management clock rate.
module clock_rate_meter
#(
	parameter int unsigned WINDOW_CYCLES = lane_status_pkg::RATE_WINDOW_CYCLES
)
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	input  wire logic        sample_i,
	output logic      [31:0] rate_o
);
	import lane_status_pkg::*;

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        s3;
		logic        level;
		logic [31:0] window;
		logic [31:0] edges;
		logic [31:0] rate;
	} meter_s;

	meter_s cur;
	meter_s next_cur;
	logic   rise;

	// A rise counts only once the second and third stages agree on a new high.
	always_comb
	begin
		next_cur = cur;
		rise = 1'b0;
		if (ce_i)
		begin
			next_cur.s1 = sample_i;
			next_cur.s2 = cur.s1;
			next_cur.s3 = cur.s2;
			if (cur.s2 == cur.s3)
			begin
				rise = cur.s3 & ~cur.level;
				next_cur.level = cur.s3;
			end
			if (cur.window == 32'(WINDOW_CYCLES - 1))
			begin
				next_cur.window = 32'h0000_0000;
				next_cur.rate = cur.edges + 32'(rise);
				next_cur.edges = 32'h0000_0000;
			end
			else
			begin
				next_cur.window = cur.window + 32'h0000_0001;
				next_cur.edges = cur.edges + 32'(rise);
			end
		end
		if (reset_i)
		begin
			next_cur = '0;
		end
	end

	// State register.
	always_ff @(posedge clk_i)
	begin
		cur <= next_cur;
	end

	assign rate_o = cur.rate;

endmodule

/* File: hdl/lane_link_status_registers.sv */
// Read-only status and diagnostic register bank of a multi-lane packet link core.
// Assumes flags and sampled clocks arrive from other domains; reads come on the management port.
module lane_link_status_registers
#(
	parameter int unsigned NUM_LANES          = 12,
	parameter int unsigned NUM_XCVR_BLOCKS    = 2,
	parameter logic [31:0] USED_BLOCKS        = 32'h0000_0003,
	parameter bit          SHARED_PLL         = 1'b0,
	parameter bit          HAS_CORE_RATE      = 1'b0,
	parameter int unsigned CYCLES_PER_SECOND  = lane_status_pkg::CYCLES_PER_SECOND,
	parameter int unsigned RATE_WINDOW_CYCLES = lane_status_pkg::RATE_WINDOW_CYCLES
)
(
	input  wire logic                                clk_i,
	input  wire logic                                reset_i,
	input  wire logic                                ce_i,
	input  wire logic [lane_status_pkg::ADDR_W-1:0]  mgmt_address_i,
	input  wire logic                                mgmt_read_i,
	output logic      [lane_status_pkg::DATA_W-1:0]  mgmt_readdata_o,
	output logic                                     mgmt_readdatavalid_o,
	input  wire logic [NUM_LANES-1:0]                send_drained_i,
	input  wire logic [NUM_LANES-1:0]                send_full_i,
	input  wire logic [NUM_LANES-1:0]                send_low_i,
	input  wire logic [NUM_LANES-1:0]                send_high_i,
	input  wire logic [NUM_LANES-1:0]                recv_drained_i,
	input  wire logic [NUM_LANES-1:0]                recv_full_i,
	input  wire logic [NUM_LANES-1:0]                recv_low_i,
	input  wire logic [NUM_LANES-1:0]                recv_high_i,
	input  wire logic [NUM_LANES-1:0]                cdr_lock_i,
	input  wire logic [NUM_XCVR_BLOCKS-1:0]          tx_pll_lock_i,
	input  wire logic                                core_pll_lock_i,
	input  wire logic                                core_clock_i,
	input  wire logic                                recovered_clock_i,
	input  wire logic                                serial_clock_i
);
	import lane_status_pkg::*;

	localparam int FLAG_W   = FLAG_GROUPS * NUM_LANES + NUM_XCVR_BLOCKS + 1;
	localparam int PLL_BASE = FLAG_GROUPS * NUM_LANES;
	localparam int CORE_PLL = FLAG_W - 1;

	typedef struct packed {
		logic [DATA_W-1:0]    rdata;
		logic                 rvalid;
		logic [SECONDS_W-1:0] secs;
		logic [31:0]          tick;
		logic [FLAG_W-1:0]    s1;
		logic [FLAG_W-1:0]    s2;
		logic [FLAG_W-1:0]    s3;
		logic [FLAG_W-1:0]    live;
	} bank_s;

	bank_s             cur;
	bank_s             next_cur;
	logic [FLAG_W-1:0] raw_flags;
	logic [FLAG_W-1:0] agree;
	logic [31:0]       core_rate;
	logic [31:0]       recovered_rate;
	logic [31:0]       serial_rate;
	logic [DATA_W-1:0] word;

	// Pulls one per-lane flag group out of the flag vector, zero above the lanes.
	function automatic logic [DATA_W-1:0] lane_flags(input logic [FLAG_W-1:0] v, input int grp);
		logic [DATA_W-1:0] w;
		w = '0;
		for (int i = 0; i < NUM_LANES; i++)
		begin
			w[i] = v[grp * NUM_LANES + i];
		end
		return w;
	endfunction

	// Builds the PLL lock word for either variant.
	function automatic logic [DATA_W-1:0] pll_word(input logic [FLAG_W-1:0] v);
		logic [DATA_W-1:0] w;
		w = '0;
		if (SHARED_PLL)
		begin
			w[SHARED_TX_PLL_BIT] = v[PLL_BASE];
			w[SHARED_CORE_PLL_BIT] = v[CORE_PLL];
		end
		else
		begin
			for (int i = 0; i < NUM_XCVR_BLOCKS; i++)
			begin
				w[i] = v[PLL_BASE + i] | ~USED_BLOCKS[i];
			end
		end
		return w;
	endfunction

	// Gathers every asynchronous flag into one vector for the synchronisers.
	assign raw_flags = {core_pll_lock_i, tx_pll_lock_i, cdr_lock_i,
		recv_high_i, recv_low_i, recv_full_i, recv_drained_i,
		send_high_i, send_low_i, send_full_i, send_drained_i};
	assign agree = ~(cur.s2 ^ cur.s3);

	// Rate meters for the three monitored clocks.
	clock_rate_meter #(.WINDOW_CYCLES(RATE_WINDOW_CYCLES)) core_meter
	(
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.ce_i     (ce_i),
		.sample_i (core_clock_i),
		.rate_o   (core_rate)
	);

	clock_rate_meter #(.WINDOW_CYCLES(RATE_WINDOW_CYCLES)) recovered_meter
	(
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.ce_i     (ce_i),
		.sample_i (recovered_clock_i),
		.rate_o   (recovered_rate)
	);

	clock_rate_meter #(.WINDOW_CYCLES(RATE_WINDOW_CYCLES)) serial_meter
	(
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.ce_i     (ce_i),
		.sample_i (serial_clock_i),
		.rate_o   (serial_rate)
	);

	// Read decode; nothing here changes state, so a read has no side effect.
	always_comb
	begin
		word = '0;
		case (mgmt_address_i)
			OFS_LANE_TOTAL:
				word = {{(DATA_W - LANE_FIELD_W){1'b0}}, LANE_FIELD_W'(NUM_LANES)};
			OFS_SECONDS_SINCE_START:
				word = {{(DATA_W - SECONDS_W){1'b0}}, cur.secs};
			OFS_SEND_DRAINED:
				word = lane_flags(cur.live, GRP_SEND_DRAINED);
			OFS_SEND_FULL:
				word = lane_flags(cur.live, GRP_SEND_FULL);
			OFS_SEND_LOW:
				word = lane_flags(cur.live, GRP_SEND_LOW);
			OFS_SEND_HIGH:
				word = lane_flags(cur.live, GRP_SEND_HIGH);
			OFS_RECV_DRAINED:
				word = lane_flags(cur.live, GRP_RECV_DRAINED);
			OFS_RECV_FULL:
				word = lane_flags(cur.live, GRP_RECV_FULL);
			OFS_RECV_LOW:
				word = lane_flags(cur.live, GRP_RECV_LOW);
			OFS_RECV_HIGH:
				word = lane_flags(cur.live, GRP_RECV_HIGH);
			OFS_CORE_CLOCK_RATE:
				word = HAS_CORE_RATE ? core_rate : '0;
			OFS_RECOVERED_RATE:
				word = recovered_rate;
			OFS_SERIAL_RATE:
				word = serial_rate;
			OFS_PLL_LOCK:
				word = pll_word(cur.live);
			OFS_CDR_LOCK:
				word = lane_flags(cur.live, GRP_CDR_LOCK);
			default:
				word = '0;
		endcase
	end

	// Next state: synchronisers, seconds count and the read answer.
	always_comb
	begin
		next_cur = cur;
		if (ce_i)
		begin
			next_cur.s1 = raw_flags;
			next_cur.s2 = cur.s1;
			next_cur.s3 = cur.s2;
			next_cur.live = (agree & cur.s3) | (~agree & cur.live);
			if (cur.tick == 32'(CYCLES_PER_SECOND - 1))
			begin
				next_cur.tick = 32'h0000_0000;
				next_cur.secs = cur.secs + 1'b1;
			end
			else
			begin
				next_cur.tick = cur.tick + 32'h0000_0001;
			end
			next_cur.rvalid = mgmt_read_i;
			if (mgmt_read_i)
			begin
				next_cur.rdata = word;
			end
		end
		if (reset_i)
		begin
			next_cur = '0;
		end
	end

	// State register.
	always_ff @(posedge clk_i)
	begin
		cur <= next_cur;
	end

	assign mgmt_readdata_o = cur.rdata;
	assign mgmt_readdatavalid_o = cur.rvalid;

	default clocking dc @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// A taken read is answered on the next edge.
	property p_read_answered;
		ce_i && mgmt_read_i |=> mgmt_readdatavalid_o;
	endproperty
	a_read_answered: assert property (p_read_answered)
		else $error("read not answered one cycle later");

	// No answer without a read.
	property p_no_spurious_answer;
		ce_i && !mgmt_read_i |=> !mgmt_readdatavalid_o;
	endproperty
	a_no_spurious_answer: assert property (p_no_spurious_answer)
		else $error("answer without a read");

	// Reserved addresses above the CDR lock word read as zero.
	property p_reserved_zero;
		ce_i && mgmt_read_i && mgmt_address_i > OFS_CDR_LOCK |=> mgmt_readdata_o == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved address returned nonzero data");

	// Lane total reads the configured count.
	property p_lane_total;
		ce_i && mgmt_read_i && mgmt_address_i == OFS_LANE_TOTAL
			|=> mgmt_readdata_o == DATA_W'(NUM_LANES);
	endproperty
	a_lane_total: assert property (p_lane_total)
		else $error("lane total wrong");

	// Seconds advance by one and the tick returns to zero when the tick wraps.
	property p_seconds_step;
		ce_i && cur.tick == 32'(CYCLES_PER_SECOND - 1)
			|=> cur.secs == $past(cur.secs) + 1'b1 && cur.tick == '0;
	endproperty
	a_seconds_step: assert property (p_seconds_step)
		else $error("seconds did not advance on tick wrap");

	// Transmit empty flags read back the live per-lane value.
	property p_send_drained;
		ce_i && mgmt_read_i && mgmt_address_i == OFS_SEND_DRAINED
			|=> mgmt_readdata_o == lane_flags($past(cur.live), GRP_SEND_DRAINED);
	endproperty
	a_send_drained: assert property (p_send_drained)
		else $error("transmit empty flags misread");

	// Lock flags read back the live per-lane value.
	property p_cdr_lock;
		ce_i && mgmt_read_i && mgmt_address_i == OFS_CDR_LOCK
			|=> mgmt_readdata_o == lane_flags($past(cur.live), GRP_CDR_LOCK);
	endproperty
	a_cdr_lock: assert property (p_cdr_lock)
		else $error("frequency lock flags misread");

	// A flag stable for three edges reaches the live copy.
	property p_flag_follows;
		ce_i && raw_flags[0] ##1 ce_i && raw_flags[0] ##1 ce_i && raw_flags[0] ##1 ce_i
			|=> cur.live[0];
	endproperty
	a_flag_follows: assert property (p_flag_follows)
		else $error("stable flag not reflected");

	// Recovered clock rate reads the meter result.
	property p_recovered_rate;
		ce_i && mgmt_read_i && mgmt_address_i == OFS_RECOVERED_RATE
			|=> mgmt_readdata_o == $past(recovered_rate);
	endproperty
	a_recovered_rate: assert property (p_recovered_rate)
		else $error("recovered rate misread");

	// Unused PLL blocks read as locked in the per-block variant.
	property p_unused_pll_one;
		ce_i && mgmt_read_i && mgmt_address_i == OFS_PLL_LOCK && !SHARED_PLL
			|=> (mgmt_readdata_o[NUM_XCVR_BLOCKS-1:0] | USED_BLOCKS[NUM_XCVR_BLOCKS-1:0])
				== {NUM_XCVR_BLOCKS{1'b1}};
	endproperty
	a_unused_pll_one: assert property (p_unused_pll_one)
		else $error("unused PLL bit not one");

endmodule

/* File: hdl/lane_status_pkg.sv */
// Shared constants for the lane link status register bank.
// Assumes a single 20 MHz management clock and word-indexed register offsets.
package lane_status_pkg;

	// Management port geometry.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// Register offsets, one 32-bit word each.
	localparam logic [ADDR_W-1:0] OFS_LANE_TOTAL          = 16'h0001;
	localparam logic [ADDR_W-1:0] OFS_SECONDS_SINCE_START = 16'h0003;
	localparam logic [ADDR_W-1:0] OFS_SEND_DRAINED        = 16'h0004;
	localparam logic [ADDR_W-1:0] OFS_SEND_FULL           = 16'h0005;
	localparam logic [ADDR_W-1:0] OFS_SEND_LOW            = 16'h0006;
	localparam logic [ADDR_W-1:0] OFS_SEND_HIGH           = 16'h0007;
	localparam logic [ADDR_W-1:0] OFS_RECV_DRAINED        = 16'h0008;
	localparam logic [ADDR_W-1:0] OFS_RECV_FULL           = 16'h0009;
	localparam logic [ADDR_W-1:0] OFS_RECV_LOW            = 16'h000A;
	localparam logic [ADDR_W-1:0] OFS_RECV_HIGH           = 16'h000B;
	localparam logic [ADDR_W-1:0] OFS_CORE_CLOCK_RATE     = 16'h000C;
	localparam logic [ADDR_W-1:0] OFS_RECOVERED_RATE      = 16'h000D;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_RATE         = 16'h000E;
	localparam logic [ADDR_W-1:0] OFS_PLL_LOCK            = 16'h0010;
	localparam logic [ADDR_W-1:0] OFS_CDR_LOCK            = 16'h0011;

	// Field layouts.
	localparam int LANE_FIELD_W        = 8;
	localparam int SECONDS_W           = 24;
	localparam int SHARED_TX_PLL_BIT   = 0;
	localparam int SHARED_CORE_PLL_BIT = 16;

	// Order of the per-lane flag groups inside the synchronised flag vector.
	localparam int GRP_SEND_DRAINED = 0;
	localparam int GRP_SEND_FULL    = 1;
	localparam int GRP_SEND_LOW     = 2;
	localparam int GRP_SEND_HIGH    = 3;
	localparam int GRP_RECV_DRAINED = 4;
	localparam int GRP_RECV_FULL    = 5;
	localparam int GRP_RECV_LOW     = 6;
	localparam int GRP_RECV_HIGH    = 7;
	localparam int GRP_CDR_LOCK     = 8;
	localparam int FLAG_GROUPS      = 9;

	// Timing: one second of elapsed time and one rate measuring window.
	localparam int CLK_PERIOD_NS      = 50;
	localparam int SECOND_NS          = 1_000_000_000;
	localparam int CYCLES_PER_SECOND  = SECOND_NS / CLK_PERIOD_NS;
	localparam int RATE_WINDOW_NS     = 1_000_000;
	localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_NS / CLK_PERIOD_NS;

endpackage
